//--- rtl/irs_pkg_sync.sv
package irs_pkg;

   // Seven-bit bus addresses picked by the address-select pin.
   localparam logic [6:0] IRS_ADDR_SEL_LOW = 7'h30;
   localparam logic [6:0] IRS_ADDR_SEL_HIGH = 7'h32;

   // Direction bit values in the address byte.
   localparam logic IRS_DIR_WRITE = 1'b0;
   localparam logic IRS_DIR_READ = 1'b1;

   // Byte framing: eight data bits, then the acknowledge bit.
   localparam int IRS_BYTE_BITS = 8;
   localparam logic [3:0] IRS_BITS_DONE = 4'h8;

   // Reset values.
   localparam logic [7:0] IRS_PTR_RESET = 8'h00;
   localparam logic [7:0] IRS_DATA_RESET = 8'h00;

   // Bus speeds served, and the oversampling margin the link clock needs.
   localparam int IRS_STD_SCL_KHZ = 100;
   localparam int IRS_FAST_SCL_KHZ = 400;
   localparam int IRS_MIN_OVERSAMPLE = 16;
   localparam int IRS_LINK_CLK_KHZ = 66667;

   // Register request crossing from the link side to the system side.
   typedef struct packed {
      logic wr;
      logic [7:0] addr;
      logic [7:0] data;
   } irs_req_t;

   // Link-side protocol states.
   typedef enum logic [2:0] {
      IRS_ST_IDLE,
      IRS_ST_ADDR,
      IRS_ST_ADDR_ACK,
      IRS_ST_RX,
      IRS_ST_RX_ACK,
      IRS_ST_TX,
      IRS_ST_TX_ACK,
      IRS_ST_WAIT
   } irs_state_t;

endpackage

`timescale 1ns/1ps
`default_nettype none

// Two flip-flop level synchroniser; the first stage feeds only the second.
module irs_sync2 #(
   parameter int W = 1
) (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic [W-1:0] d_i,
   output logic [W-1:0] q_o
);

   logic [W-1:0] meta_r;

   // Both stages clear on reset and then follow the input two edges late.
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         meta_r <= '0;
         q_o <= '0;
      end else begin
         meta_r <= d_i;
         q_o <= meta_r;
      end
   end

endmodule

`default_nettype wire

//--- rtl/irs_slave.sv
// Functional notes
// - SDA falling while SCL high starts transfer.
// - SDA rising while SCL high ends transfer.
// - Change SDA only while SCL is low.
// - Bytes of eight bits, MSB first, acknowledged.
// - Acknowledger holds SDA low during ninth pulse.
// - Serve 100 kHz and 400 kHz clock rates.
// - Answer address 0x30, or 0x32 when selected.
// - Address LSB zero writes, one reads.
// - Acknowledge matching address in both directions.
// - First written byte loads the register pointer.
// - Later written bytes store, acknowledge, advance pointer.
// - Reads start at the current stored pointer.
// - On not-acknowledge stop sending, release SDA.
// - Repeated start begins a new transfer cleanly.
// - No limit on bytes per transfer.
// - SDA only pulled low or released.

`timescale 1ns/1ps
`default_nettype none

module irs_slave
   import irs_pkg::*;
#(
   parameter int LINK_CLK_KHZ = IRS_LINK_CLK_KHZ
) (
   input wire logic clock_i,
   input wire logic reset_i,
   input wire logic link_clk_i,
   input wire logic scl_i,
   input wire logic sda_i,
   output logic sda_o,
   output logic sda_oe_o,
   input wire logic addr_sel_i,
   output logic reg_wr_o,
   output logic reg_rd_o,
   output logic [7:0] reg_addr_o,
   output logic [7:0] reg_wdata_o,
   input wire logic [7:0] reg_rdata_i,
   output logic bus_busy_o
);

   // The link clock must sample SCL often enough for fast-mode timing.
   if (LINK_CLK_KHZ < IRS_MIN_OVERSAMPLE * IRS_FAST_SCL_KHZ) begin : g_link_clk_check
      $error("link clock too slow to oversample the serial clock");
   end

   // Link domain reset: asserted at once, released on the link clock.
   logic [1:0] link_rst_r;
   logic link_rst;

   always_ff @(posedge link_clk_i or posedge reset_i) begin
      if (reset_i) begin
         link_rst_r <= 2'h3;
      end else begin
         link_rst_r <= {link_rst_r[0], 1'b0};
      end
   end

   assign link_rst = link_rst_r[1];

   // Pin sampling in the link domain.
   logic [2:0] pins_s;
   logic scl_s, sda_s, sel_s;
   logic scl_d_r, sda_d_r;

   irs_sync2 #(
      .W(3)
   ) u_pin_sync (
      .clk_i(link_clk_i),
      .rst_i(link_rst),
      .d_i({addr_sel_i, sda_i, scl_i}),
      .q_o(pins_s)
   );

   assign scl_s = pins_s[0];
   assign sda_s = pins_s[1];
   assign sel_s = pins_s[2];

   // Previous synchronised levels, used for edge detection.
   always_ff @(posedge link_clk_i or posedge link_rst) begin
      if (link_rst) begin
         scl_d_r <= 1'b1;
         sda_d_r <= 1'b1;
      end else begin
         scl_d_r <= scl_s;
         sda_d_r <= sda_s;
      end
   end

   // Bus events decoded from the oversampled lines.
   logic scl_rise, scl_fall, start_evt, stop_evt;

   assign scl_rise = scl_s & ~scl_d_r;
   assign scl_fall = ~scl_s & scl_d_r;
   assign start_evt = scl_s & scl_d_r & sda_d_r & ~sda_s;
   assign stop_evt = scl_s & scl_d_r & ~sda_d_r & sda_s;

   // Link-side protocol state.
   irs_state_t state_r, state_nxt;
   logic [3:0] bit_cnt_r, bit_cnt_nxt;
   logic [7:0] shift_r, shift_nxt;
   logic [7:0] tx_r, tx_nxt;
   logic [7:0] ptr_r, ptr_nxt;
   logic sda_low_r, sda_low_nxt;
   logic first_r, first_nxt;
   logic master_ack_r, master_ack_nxt;
   logic busy_r, busy_nxt;
   irs_req_t req_r, req_nxt;
   logic req_tgl_r, req_fire;
   logic [7:0] rd_data_r;

   // Own address depends on the select pin; the LSB of the byte is direction.
   logic [6:0] own_addr;
   logic addr_match, byte_done, dir_read;

   assign own_addr = sel_s ? IRS_ADDR_SEL_HIGH : IRS_ADDR_SEL_LOW;
   assign addr_match = (shift_r[7:1] == own_addr);
   assign dir_read = (shift_r[0] == IRS_DIR_READ);
   assign byte_done = (bit_cnt_r == IRS_BITS_DONE);

   // Next-state logic; the line is only ever changed on a falling SCL edge.
   always_comb begin
      state_nxt = state_r;
      bit_cnt_nxt = bit_cnt_r;
      shift_nxt = shift_r;
      tx_nxt = tx_r;
      ptr_nxt = ptr_r;
      sda_low_nxt = sda_low_r;
      first_nxt = first_r;
      master_ack_nxt = master_ack_r;
      busy_nxt = busy_r;
      req_nxt = req_r;
      req_fire = 1'b0;
      if (start_evt) begin
         state_nxt = IRS_ST_ADDR;
         bit_cnt_nxt = 4'h0;
         sda_low_nxt = 1'b0;
         busy_nxt = 1'b1;
      end else if (stop_evt) begin
         state_nxt = IRS_ST_IDLE;
         sda_low_nxt = 1'b0;
         busy_nxt = 1'b0;
      end else begin
         unique case (state_r)
            IRS_ST_IDLE, IRS_ST_WAIT: begin
               sda_low_nxt = 1'b0;
            end
            IRS_ST_ADDR, IRS_ST_RX: begin
               if (scl_rise) begin
                  shift_nxt = {shift_r[6:0], sda_s};
                  bit_cnt_nxt = bit_cnt_r + 4'h1;
               end else if (scl_fall && byte_done) begin
                  if (state_r == IRS_ST_ADDR) begin
                     if (addr_match) begin
                        sda_low_nxt = 1'b1;
                        state_nxt = IRS_ST_ADDR_ACK;
                        if (dir_read) begin
                           // Fetch the first byte from the stored pointer.
                           req_nxt = '{wr: 1'b0, addr: ptr_r, data: IRS_DATA_RESET};
                           req_fire = 1'b1;
                           ptr_nxt = ptr_r + 8'h01;
                        end
                     end else begin
                        state_nxt = IRS_ST_WAIT;
                     end
                  end else begin
                     sda_low_nxt = 1'b1;
                     state_nxt = IRS_ST_RX_ACK;
                     if (first_r) begin
                        ptr_nxt = shift_r;
                     end else begin
                        req_nxt = '{wr: 1'b1, addr: ptr_r, data: shift_r};
                        req_fire = 1'b1;
                        ptr_nxt = ptr_r + 8'h01;
                     end
                  end
               end
            end
            IRS_ST_ADDR_ACK: begin
               if (scl_fall) begin
                  bit_cnt_nxt = 4'h0;
                  if (dir_read) begin
                     // Present the first data bit as the ack pulse ends.
                     state_nxt = IRS_ST_TX;
                     tx_nxt = rd_data_r;
                     sda_low_nxt = ~rd_data_r[7];
                  end else begin
                     state_nxt = IRS_ST_RX;
                     first_nxt = 1'b1;
                     sda_low_nxt = 1'b0;
                  end
               end
            end
            IRS_ST_RX_ACK: begin
               if (scl_fall) begin
                  // Release after the ack pulse; any number of bytes may follow.
                  sda_low_nxt = 1'b0;
                  bit_cnt_nxt = 4'h0;
                  first_nxt = 1'b0;
                  state_nxt = IRS_ST_RX;
               end
            end
            IRS_ST_TX: begin
               if (scl_rise) begin
                  bit_cnt_nxt = bit_cnt_r + 4'h1;
               end else if (scl_fall) begin
                  if (byte_done) begin
                     // Let go so the master can answer the ninth bit.
                     sda_low_nxt = 1'b0;
                     state_nxt = IRS_ST_TX_ACK;
                  end else begin
                     tx_nxt = {tx_r[6:0], 1'b0};
                     sda_low_nxt = ~tx_r[6];
                  end
               end
            end
            IRS_ST_TX_ACK: begin
               if (scl_rise) begin
                  master_ack_nxt = ~sda_s;
                  if (!sda_s) begin
                     req_nxt = '{wr: 1'b0, addr: ptr_r, data: IRS_DATA_RESET};
                     req_fire = 1'b1;
                     ptr_nxt = ptr_r + 8'h01;
                  end
               end else if (scl_fall) begin
                  bit_cnt_nxt = 4'h0;
                  if (master_ack_r) begin
                     state_nxt = IRS_ST_TX;
                     tx_nxt = rd_data_r;
                     sda_low_nxt = ~rd_data_r[7];
                  end else begin
                     state_nxt = IRS_ST_WAIT;
                     sda_low_nxt = 1'b0;
                  end
               end
            end
         endcase
      end
   end

   // Link-side state registers.
   always_ff @(posedge link_clk_i or posedge link_rst) begin
      if (link_rst) begin
         state_r <= IRS_ST_IDLE;
         bit_cnt_r <= 4'h0;
         shift_r <= IRS_DATA_RESET;
         tx_r <= IRS_DATA_RESET;
         ptr_r <= IRS_PTR_RESET;
         sda_low_r <= 1'b0;
         first_r <= 1'b0;
         master_ack_r <= 1'b0;
         busy_r <= 1'b0;
      end else begin
         state_r <= state_nxt;
         bit_cnt_r <= bit_cnt_nxt;
         shift_r <= shift_nxt;
         tx_r <= tx_nxt;
         ptr_r <= ptr_nxt;
         sda_low_r <= sda_low_nxt;
         first_r <= first_nxt;
         master_ack_r <= master_ack_nxt;
         busy_r <= busy_nxt;
      end
   end

   // Request word is held stable and announced by a toggle.
   always_ff @(posedge link_clk_i or posedge link_rst) begin
      if (link_rst) begin
         req_r <= '0;
         req_tgl_r <= 1'b0;
      end else begin
         req_r <= req_nxt;
         if (req_fire) begin
            req_tgl_r <= ~req_tgl_r;
         end
      end
   end

   // The pin is open drain: the driven level is always low.
   assign sda_o = 1'b0;
   assign sda_oe_o = sda_low_r;

   // System domain: register access on behalf of the link.
   logic [1:0] sys_s;
   logic req_d_r, req_evt, ack_tgl_r;
   logic [7:0] rdata_r;

   irs_sync2 #(
      .W(2)
   ) u_sys_sync (
      .clk_i(clock_i),
      .rst_i(reset_i),
      .d_i({busy_r, req_tgl_r}),
      .q_o(sys_s)
   );

   assign req_evt = sys_s[0] ^ req_d_r;

   // One strobe per request; read data is taken while the read strobe is up.
   always_ff @(posedge clock_i or posedge reset_i) begin
      if (reset_i) begin
         req_d_r <= 1'b0;
         reg_wr_o <= 1'b0;
         reg_rd_o <= 1'b0;
         reg_addr_o <= IRS_PTR_RESET;
         reg_wdata_o <= IRS_DATA_RESET;
         bus_busy_o <= 1'b0;
      end else begin
         req_d_r <= sys_s[0];
         reg_wr_o <= req_evt & req_r.wr;
         reg_rd_o <= req_evt & ~req_r.wr;
         bus_busy_o <= sys_s[1];
         if (req_evt) begin
            reg_addr_o <= req_r.addr;
            reg_wdata_o <= req_r.data;
         end
      end
   end

   // Answer toggle and held read data back to the link.
   always_ff @(posedge clock_i or posedge reset_i) begin
      if (reset_i) begin
         ack_tgl_r <= 1'b0;
         rdata_r <= IRS_DATA_RESET;
      end else begin
         if (reg_rd_o) begin
            rdata_r <= reg_rdata_i;
         end
         if (reg_rd_o | reg_wr_o) begin
            ack_tgl_r <= ~ack_tgl_r;
         end
      end
   end

   // Answer crossing into the link domain.
   logic ack_s, ack_d_r;

   irs_sync2 #(
      .W(1)
   ) u_ack_sync (
      .clk_i(link_clk_i),
      .rst_i(link_rst),
      .d_i(ack_tgl_r),
      .q_o(ack_s)
   );

   // Read data is stable in the system domain once the toggle is seen.
   always_ff @(posedge link_clk_i or posedge link_rst) begin
      if (link_rst) begin
         ack_d_r <= 1'b0;
         rd_data_r <= IRS_DATA_RESET;
      end else begin
         ack_d_r <= ack_s;
         if (ack_s ^ ack_d_r) begin
            rd_data_r <= rdata_r;
         end
      end
   end

endmodule

`default_nettype wire

//--- verification/irs_slave_checker.sv
`timescale 1ns/1ps
`default_nettype none

// Watches the bus pins and the register strobes of the slave.
module irs_slave_checker (
   input wire logic clock_i,
   input wire logic reset_i,
   input wire logic link_clk_i,
   input wire logic scl_i,
   input wire logic sda_i,
   input wire logic sda_o,
   input wire logic sda_oe_o,
   input wire logic reg_wr_o,
   input wire logic reg_rd_o,
   input wire logic bus_busy_o
);
   // An acknowledge or data low is held for several link clocks once it starts.
   sequence s_ack_hold;
      sda_oe_o [*8];
   endsequence

   property p_oe_low;
      @(posedge link_clk_i) disable iff (reset_i) sda_oe_o |-> !sda_o && !sda_i;
   endproperty
   a_oe_low: assert property (p_oe_low) else $error("SDA driven high");

   property p_rise_scl_low;
      @(posedge link_clk_i) disable iff (reset_i) $rose(sda_oe_o) |-> !scl_i;
   endproperty
   a_rise_scl_low: assert property (p_rise_scl_low) else $error("SDA pulled with SCL high");

   property p_hold_high;
      @(posedge link_clk_i) disable iff (reset_i) scl_i && sda_oe_o |=> sda_oe_o;
   endproperty
   a_hold_high: assert property (p_hold_high) else $error("SDA let go with SCL high");

   property p_ack_hold;
      @(posedge link_clk_i) disable iff (reset_i) $rose(sda_oe_o) |-> s_ack_hold;
   endproperty
   a_ack_hold: assert property (p_ack_hold) else $error("SDA low too short");

   property p_wr_pulse;
      @(posedge clock_i) disable iff (reset_i) reg_wr_o |=> !reg_wr_o;
   endproperty
   a_wr_pulse: assert property (p_wr_pulse) else $error("Write strobe too long");

   property p_rd_pulse;
      @(posedge clock_i) disable iff (reset_i) reg_rd_o |=> !reg_rd_o && !reg_wr_o;
   endproperty
   a_rd_pulse: assert property (p_rd_pulse) else $error("Read strobe too long");

   property p_busy_start;
      @(posedge clock_i) disable iff (reset_i) $rose(bus_busy_o) |-> !sda_i;
   endproperty
   a_busy_start: assert property (p_busy_start) else $error("Busy without start");

   property p_busy_stop;
      @(posedge clock_i) disable iff (reset_i) $fell(bus_busy_o) |-> sda_i && scl_i;
   endproperty
   a_busy_stop: assert property (p_busy_stop) else $error("Busy ended without stop");

   property p_idle_released;
      @(posedge clock_i) disable iff (reset_i) !bus_busy_o |-> !sda_oe_o;
   endproperty
   a_idle_released: assert property (p_idle_released) else $error("SDA pulled on idle bus");
endmodule

bind irs_slave irs_slave_checker u_chk (
   .clock_i(clock_i), .reset_i(reset_i), .link_clk_i(link_clk_i), .scl_i(scl_i),
   .sda_i(sda_i), .sda_o(sda_o), .sda_oe_o(sda_oe_o), .reg_wr_o(reg_wr_o),
   .reg_rd_o(reg_rd_o), .bus_busy_o(bus_busy_o)
);

`default_nettype wire

//--- verification/irs_master_model.sv
`timescale 1ns/1ps
`default_nettype none

// Two-wire bus master; SCL stands still high outside frames.
module irs_master_model #(
   parameter int Q = 625
) (
   input wire logic sda_i,
   output logic scl_o,
   output logic sda_oe_o
);
   // Bus starts idle with both lines high.
   initial begin
      scl_o = 1'b1;
      sda_oe_o = 1'b0;
   end

   // START: SDA falls while SCL is high.
   task automatic start();
      #Q sda_oe_o = 1'b0;
      #Q scl_o = 1'b1;
      #Q sda_oe_o = 1'b1;
      #Q scl_o = 1'b0;
   endtask

   // STOP: SDA rises while SCL is high.
   task automatic stop();
      #Q sda_oe_o = 1'b1;
      #Q scl_o = 1'b1;
      #Q sda_oe_o = 1'b0;
      #Q;
   endtask

   // One bit: SDA moves only with SCL low and is sampled mid high phase.
   task automatic bit_io(input logic b, output logic r);
      #Q sda_oe_o = ~b;
      #Q scl_o = 1'b1;
      #Q r = sda_i;
      #Q scl_o = 1'b0;
   endtask

   // Byte MSB first, then the ninth bit driven at level ack_lvl.
   task automatic byte_io(input logic [7:0] tx, input logic ack_lvl,
                          output logic [7:0] rx, output logic ack);
      logic r;
      for (int i = 7; i >= 0; i--) begin
         bit_io(tx[i], r);
         rx[i] = r;
      end
      bit_io(ack_lvl, r);
      ack = ~r;
   endtask
endmodule

`default_nettype wire

//--- verification/irs_slave_test.sv
`timescale 1ns/1ps
`default_nettype none

module irs_slave_test
   import irs_pkg::*;
;
   localparam int Q = 625;
   logic clock_i = 1'b0;
   logic link_clk_i = 1'b0;
   logic reset_i = 1'b1;
   logic addr_sel_i = 1'b0;
   logic scl_w, m_oe, sda_o, sda_oe_o, reg_wr_o, reg_rd_o, bus_busy_o;
   logic [7:0] reg_addr_o, reg_wdata_o, reg_rdata_i;
   logic [7:0] mem [256];
   logic [7:0] shadow [256];
   logic [15:0] wq [$];
   logic [15:0] eq [$];
   int seed;
   int fail_count = 0;
   int compares = 0;
   wire logic sda_w;

   // Open-drain data line with pull-up, and a register file read in the strobe cycle.
   assign sda_w = ~(m_oe | (sda_oe_o & ~sda_o));
   assign reg_rdata_i = mem[reg_addr_o];

   // System clock, and a link clock of unrelated phase.
   always #2.5 clock_i = ~clock_i;
   initial begin
      #3.3;
      forever #7.5 link_clk_i = ~link_clk_i;
   end

   irs_master_model #(.Q(Q)) m (.sda_i(sda_w), .scl_o(scl_w), .sda_oe_o(m_oe));
   irs_slave dut (
      .clock_i(clock_i), .reset_i(reset_i), .link_clk_i(link_clk_i), .scl_i(scl_w),
      .sda_i(sda_w), .sda_o(sda_o), .sda_oe_o(sda_oe_o), .addr_sel_i(addr_sel_i),
      .reg_wr_o(reg_wr_o), .reg_rd_o(reg_rd_o), .reg_addr_o(reg_addr_o),
      .reg_wdata_o(reg_wdata_o), .reg_rdata_i(reg_rdata_i), .bus_busy_o(bus_busy_o)
   );

   // Register side stores each write and logs it.
   always @(posedge clock_i) begin
      if (reg_wr_o === 1'b1) begin
         mem[reg_addr_o] <= reg_wdata_o;
         wq.push_back({reg_addr_o, reg_wdata_o});
      end
   end

   // Bus address byte for a select level and direction.
   function automatic logic [7:0] dev_addr(input logic sel, input logic dir);
      return {(sel ? IRS_ADDR_SEL_HIGH : IRS_ADDR_SEL_LOW), dir};
   endfunction

   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      compares++;
      if (seen !== exp) begin
         fail_count++;
         $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   // Master sends a byte and expects the given acknowledge.
   task automatic wr_byte(input logic [7:0] b, input logic exp_ack);
      logic [7:0] rx;
      logic ack;
      m.byte_io(b, 1'b1, rx, ack);
      check(ack, exp_ack);
   endtask

   // Master reads a byte, then acknowledges or not.
   task automatic rd_byte(input logic nack, input logic [7:0] exp);
      logic [7:0] rx;
      logic ack;
      m.byte_io(8'hff, nack, rx, ack);
      check(rx, exp);
   endtask

   task automatic print_verdict();
      $display("Comparisons %0d, mismatches %0d", compares, fail_count);
      if (fail_count == 0 && compares > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask

   // The tests take about 440 us; the watchdog cuts a hung run short after 480 us.
   initial begin
      #480000;
      fail_count++;
      print_verdict();
   end

   // Main sequence.
   initial begin
      logic [7:0] p, d;
      logic hit;
      seed = 32'h6e75;
      for (int i = 0; i < 256; i++) begin
         mem[i] = 8'($random(seed));
         shadow[i] = mem[i];
      end
      repeat (20) @(posedge clock_i);
      @(negedge clock_i) reset_i = 1'b0;
      p = 8'($random(seed)) & 8'h7f;
      // Pointer write followed by two data bytes.
      m.start();
      check(bus_busy_o, 1'b1);
      wr_byte(dev_addr(1'b0, IRS_DIR_WRITE), 1'b1);
      wr_byte(p, 1'b1);
      for (int i = 0; i < 2; i++) begin
         d = 8'($random(seed));
         wr_byte(d, 1'b1);
         eq.push_back({p + 8'(i), d});
         shadow[p + 8'(i)] = d;
      end
      m.stop();
      check(bus_busy_o, 1'b0);
      // Pointer write, repeated start, two reads with the last not acknowledged.
      m.start();
      wr_byte(dev_addr(1'b0, IRS_DIR_WRITE), 1'b1);
      wr_byte(p, 1'b1);
      m.start();
      wr_byte(dev_addr(1'b0, IRS_DIR_READ), 1'b1);
      rd_byte(1'b0, shadow[p]);
      rd_byte(1'b1, shadow[p + 8'h01]);
      #100 check(sda_w, 1'b1);
      m.stop();
      // A read with no pointer write continues after the last byte sent.
      m.start();
      wr_byte(dev_addr(1'b0, IRS_DIR_READ), 1'b1);
      rd_byte(1'b1, shadow[p + 8'h02]);
      m.stop();
      // Address select table: only the selected address answers.
      for (int k = 0; k < 3; k++) begin
         @(negedge clock_i) addr_sel_i = (k != 0);
         hit = (k == 1);
         d = 8'($random(seed));
         m.start();
         wr_byte(dev_addr(k != 2, IRS_DIR_WRITE), hit);
         wr_byte(d, hit);
         if (hit) begin
            wr_byte(~d, 1'b1);
            eq.push_back({d, ~d});
         end
         m.stop();
      end
      check(16'(wq.size()), 16'(eq.size()));
      foreach (eq[i]) if (i < wq.size()) check(wq[i], eq[i]);
      print_verdict();
   end
endmodule

`default_nettype wire
